// ---- include/flash_id_pkg.sv ----
// constants shared by the identification readout logic
package flash_id_pkg;

	// ------------------------------------------------------------
	// opcodes
	// ------------------------------------------------------------
	localparam logic [7:0] OP_ID_SINGLE = 8'h90;
	localparam logic [7:0] OP_ID_QUAD   = 8'h94;
	localparam logic [7:0] OP_ID_STD    = 8'h9f;

	// ------------------------------------------------------------
	// frame timing, in rising link clock edges
	// ------------------------------------------------------------
	localparam logic [5:0] OPCODE_BITS  = 6'h08;
	localparam logic [5:0] START_SINGLE = 6'h20;
	localparam logic [5:0] START_QUAD   = 6'h14;
	localparam logic [5:0] START_STD    = 6'h08;
	localparam logic [5:0] LAST_SINGLE  = 6'h0f;
	localparam logic [5:0] LAST_QUAD    = 6'h03;
	localparam logic [5:0] LAST_STD     = 6'h27;

	// ------------------------------------------------------------
	// identification values
	// ------------------------------------------------------------
	// arbitrary value
	localparam logic [7:0] MFR_ID       = 8'h3b;
	// arbitrary value
	localparam logic [3:0] FAMILY_CODE  = 4'h2;
	// arbitrary value
	localparam logic [3:0] DENSITY_CODE = 4'h5;
	// arbitrary value
	localparam logic [3:0] SUB_CODE     = 4'h1;
	// arbitrary value
	localparam logic [3:0] VERSION_CODE = 4'h3;
	localparam logic [7:0] EXT_ID_LEN   = 8'h01;
	localparam logic [3:0] EXT_ID_HIGH  = 4'h0;
	// arbitrary value, codes 8 to f reserved
	localparam logic [3:0] VARIANT_CODE = 4'h2;

	typedef enum logic [1:0] {
		CMD_NONE,
		CMD_SINGLE,
		CMD_QUAD,
		CMD_STD
	} id_cmd_t;

endpackage : flash_id_pkg

// ---- hw/sync_2ff.sv ----
// two flip-flop level synchroniser
module sync_2ff (
	input  wire logic clk,
	input  wire logic rst,
	input  wire logic d,
	output logic      q
);

	logic meta_r;

	always_ff @(posedge clk) begin
		if (rst) begin
			meta_r <= 1'b0;
			q      <= 1'b0;
		end else begin
			meta_r <= d;
			q      <= meta_r;
		end
	end

endmodule : sync_2ff

// ---- hw/flash_id_readout.sv ----
// identification readout logic of a serial flash
module flash_id_readout (
	input  wire logic        ref_clk,
	input  wire logic        sys_rst,
	input  wire logic        link_sck,
	input  wire logic        select_n,
	input  wire logic        io0_in,
	input  wire logic        io1_in,
	input  wire logic        io2_in,
	input  wire logic        io3_in,
	output logic             io0_out,
	output logic             io0_oe_n,
	output logic             io1_out,
	output logic             io1_oe_n,
	output logic             io2_out,
	output logic             io2_oe_n,
	output logic             io3_out,
	output logic             io3_oe_n,
	output logic             id_read_done,
	output logic [7:0]       id_read_count
);
	import flash_id_pkg::*;

	// ------------------------------------------------------------
	// identification stream
	// ------------------------------------------------------------
	logic [7:0]  dev_id1;
	logic [7:0]  dev_id2;
	logic [7:0]  ext_id_val;
	logic [39:0] std_stream;
	logic [15:0] short_stream;

	assign dev_id1      = {FAMILY_CODE, DENSITY_CODE};
	assign dev_id2      = {SUB_CODE, VERSION_CODE};
	assign ext_id_val   = {EXT_ID_HIGH, VARIANT_CODE};
	assign std_stream   = {MFR_ID, dev_id1, dev_id2, EXT_ID_LEN, ext_id_val};
	assign short_stream = {MFR_ID, dev_id1};

	// ------------------------------------------------------------
	// link side: command and phase tracking
	// ------------------------------------------------------------
	logic [6:0]  op_shift_r;
	logic [5:0]  cnt_r;
	logic [5:0]  ptr_r;
	id_cmd_t     cmd_r;
	id_cmd_t     cmd_nxt;
	logic [5:0]  start_cnt;
	logic [5:0]  last_ptr;
	logic        data_phase;
	logic        done_tgl_r;
	logic        ser_bit;
	logic [3:0]  quad_nib;
	logic        pass_end;

	// per-pin launch value and enable
	logic [3:0]  launch_val;
	logic [3:0]  launch_en;
	logic [3:0]  pin_out;
	logic [3:0]  pin_oe_n;

	always_comb begin
		case ({op_shift_r, io0_in})
			OP_ID_SINGLE: cmd_nxt = CMD_SINGLE;
			OP_ID_QUAD:   cmd_nxt = CMD_QUAD;
			OP_ID_STD:    cmd_nxt = CMD_STD;
			default:      cmd_nxt = CMD_NONE;
		endcase
	end

	always_comb begin
		case (cmd_r)
			CMD_SINGLE: begin
				start_cnt = START_SINGLE;
				last_ptr  = LAST_SINGLE;
			end
			CMD_QUAD: begin
				start_cnt = START_QUAD;
				last_ptr  = LAST_QUAD;
			end
			CMD_STD: begin
				start_cnt = START_STD;
				last_ptr  = LAST_STD;
			end
			default: begin
				start_cnt = OPCODE_BITS;
				last_ptr  = LAST_SINGLE;
			end
		endcase
	end

	assign data_phase = (cmd_r != CMD_NONE) && (cnt_r == start_cnt);
	assign pass_end   = data_phase && (ptr_r == last_ptr);

	// ------------------------------------------------------------
	// link side: opcode capture and clock count
	// ------------------------------------------------------------
	// opcode shift, sampled on rising edges
	always_ff @(posedge link_sck or posedge select_n) begin
		if (select_n) begin
			op_shift_r <= 7'h00;
		end else if (cnt_r < OPCODE_BITS) begin
			op_shift_r <= {op_shift_r[5:0], io0_in};
		end
	end

	// clock count, stops where the data starts
	always_ff @(posedge link_sck or posedge select_n) begin
		if (select_n) begin
			cnt_r <= 6'h00;
		end else if (cnt_r < OPCODE_BITS) begin
			cnt_r <= cnt_r + 6'h01;
		end else if ((cmd_r != CMD_NONE) && (cnt_r != start_cnt)) begin
			cnt_r <= cnt_r + 6'h01;
		end
	end

	// command taken on the eighth rising edge
	always_ff @(posedge link_sck or posedge select_n) begin
		if (select_n) begin
			cmd_r <= CMD_NONE;
		end else if (cnt_r == OPCODE_BITS - 6'h01) begin
			cmd_r <= cmd_nxt;
		end
	end

	// ------------------------------------------------------------
	// link side: data pointer
	// ------------------------------------------------------------
	// data pointer, wraps while select stays low
	always_ff @(posedge link_sck or posedge select_n) begin
		if (select_n) begin
			ptr_r <= 6'h00;
		end else if (data_phase) begin
			if (ptr_r == last_ptr) begin
				ptr_r <= 6'h00;
			end else begin
				ptr_r <= ptr_r + 6'h01;
			end
		end
	end

	// ------------------------------------------------------------
	// link side: pass completion
	// ------------------------------------------------------------
	// one full id pass completed, reported to the system side
	always_ff @(posedge link_sck or posedge sys_rst) begin
		if (sys_rst) begin
			done_tgl_r <= 1'b0;
		end else if (!select_n && pass_end) begin
			done_tgl_r <= ~done_tgl_r;
		end
	end

	// ------------------------------------------------------------
	// link side: data selection
	// ------------------------------------------------------------
	always_comb begin
		ser_bit  = 1'b0;
		quad_nib = 4'h0;
		case (cmd_r)
			CMD_SINGLE: ser_bit = short_stream[4'(LAST_SINGLE - ptr_r)];
			CMD_STD:    ser_bit = std_stream[6'(LAST_STD - ptr_r)];
			CMD_QUAD: begin
				case (ptr_r[1:0])
					2'h0:    quad_nib = MFR_ID[7:4];
					2'h1:    quad_nib = MFR_ID[3:0];
					2'h2:    quad_nib = dev_id1[7:4];
					default: quad_nib = dev_id1[3:0];
				endcase
			end
			default: ser_bit = 1'b0;
		endcase
	end

	// ------------------------------------------------------------
	// link side: output launch on falling edges
	// ------------------------------------------------------------
	// which pins launch in this data phase
	always_comb begin
		launch_val = 4'h0;
		launch_en  = 4'h0;
		if (data_phase) begin
			if (cmd_r == CMD_QUAD) begin
				launch_val = quad_nib;
				launch_en  = 4'hf;
			end else begin
				launch_val = {2'h0, ser_bit, 1'b0};
				launch_en  = 4'h2;
			end
		end
	end

	// one launch stage per pin, floated while select is high
	for (genvar pin_idx = 0; pin_idx < 4; pin_idx++) begin : pin_stage
		logic out_r;
		logic oe_n_r;

		always_ff @(negedge link_sck or posedge select_n) begin
			if (select_n) begin
				out_r  <= 1'b0;
				oe_n_r <= 1'b1;
			end else if (launch_en[pin_idx]) begin
				out_r  <= launch_val[pin_idx];
				oe_n_r <= 1'b0;
			end
		end

		assign pin_out[pin_idx]  = out_r;
		assign pin_oe_n[pin_idx] = oe_n_r;
	end

	// ports follow the launch stages
	assign io0_out  = pin_out[0];
	assign io0_oe_n = pin_oe_n[0];
	assign io1_out  = pin_out[1];
	assign io1_oe_n = pin_oe_n[1];
	assign io2_out  = pin_out[2];
	assign io2_oe_n = pin_oe_n[2];
	assign io3_out  = pin_out[3];
	assign io3_oe_n = pin_oe_n[3];

	// ------------------------------------------------------------
	// system side: completed pass counting
	// ------------------------------------------------------------
	logic done_tgl_s;
	logic done_prev_r;
	logic primed_r;
	logic pass_seen;

	sync_2ff u_done_sync (
		.clk (ref_clk),
		.rst (sys_rst),
		.d   (done_tgl_r),
		.q   (done_tgl_s)
	);

	assign pass_seen = primed_r && (done_tgl_s != done_prev_r);

	// last synchronised toggle level
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			done_prev_r <= 1'b0;
		end else begin
			done_prev_r <= done_tgl_s;
		end
	end

	// held off for one cycle after reset
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			primed_r <= 1'b0;
		end else begin
			primed_r <= 1'b1;
		end
	end

	// ------------------------------------------------------------
	// system side: status outputs
	// ------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			id_read_done <= 1'b0;
		end else begin
			id_read_done <= pass_seen;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (sys_rst) begin
			id_read_count <= 8'h00;
		end else if (pass_seen) begin
			id_read_count <= id_read_count + 8'h01;
		end
	end

	// ------------------------------------------------------------
	// unused pin inputs
	// ------------------------------------------------------------
	// io1 to io3 inputs, not read anywhere in this logic; only io0_in carries the opcode
	logic unused_in;
	assign unused_in = io1_in ^ io2_in ^ io3_in;

endmodule : flash_id_readout

// ---- verif/flash_host_model.sv ----
// host controller model driving the serial link
module flash_host_model (
	output logic            sck,
	output logic            sel_n,
	output logic [3:0]      hio,
	input  wire logic [3:0] rx
);
	timeunit 1ns;
	timeprecision 1ps;
	int   seed = 67622;
	event got;
	initial begin
		sck = 1'b0;
		sel_n <= 1'b1;
		hio = 4'h0;
	end
	// ----
	// link cycles, mode 0, clock still outside frames
	// ----
	task automatic tick(input logic [3:0] v, input bit cap);
		hio <= v;
		#32 sck = 1'b1;
		if (cap)
			-> got;
		#32 sck = 1'b0;
	endtask : tick
	task automatic frame(input logic [7:0] op, input int dum, input int n);
		int i;
		#3 sel_n <= 1'b0;
		for (i = 0; i < 8; i++)
			tick({3'($random(seed)), op[7-i]}, 1'b0);
		for (i = 0; i < dum; i++)
			tick(4'($random(seed)), 1'b0);
		for (i = 0; i < n; i++)
			tick(4'($random(seed)), 1'b1);
		#3 sel_n <= 1'b1;
		#200;
	endtask : frame
endmodule : flash_host_model

// ---- verif/flash_id_readout_sva.sv ----
// concurrent checks of the identification readout ports
module flash_id_readout_sva
	import flash_id_pkg::*;
(
	input wire logic       ref_clk,
	input wire logic       sys_rst,
	input wire logic       link_sck,
	input wire logic       select_n,
	input wire logic       io0_oe_n,
	input wire logic       io1_oe_n,
	input wire logic       io2_oe_n,
	input wire logic       io3_oe_n,
	input wire logic       io1_out,
	input wire logic       id_read_done,
	input wire logic [7:0] id_read_count
);
	logic [5:0] edges_r;
	always_ff @(posedge link_sck or posedge select_n) begin
		if (select_n)
			edges_r <= 6'h00;
		else if (edges_r != 6'h3f)
			edges_r <= edges_r + 6'h01;
	end
	sequence s_bit_start;
		$fell(io1_oe_n) && io0_oe_n;
	endsequence
	sequence s_nib_start;
		$fell(io1_oe_n) && !io0_oe_n;
	endsequence
	// ----
	// checks
	// ----
	AST_OPCODE_QUIET: assert property (@(posedge link_sck) disable iff (select_n)
		edges_r < OPCODE_BITS |-> io0_oe_n && io1_oe_n) else $error("early drive");
	AST_SERIAL_START: assert property (@(posedge link_sck) disable iff (select_n)
		s_bit_start |-> edges_r == START_SINGLE || edges_r == START_STD) else $error("bad start");
	AST_QUAD_START: assert property (@(posedge link_sck) disable iff (select_n)
		s_nib_start |-> edges_r == START_QUAD) else $error("bad quad start");
	AST_MFR_FIRST: assert property (@(posedge link_sck) disable iff (select_n)
		s_bit_start |-> io1_out == MFR_ID[7]) else $error("bad first bit");
	AST_QUAD_ALL: assert property (@(posedge link_sck) disable iff (select_n)
		!io0_oe_n |-> !(io1_oe_n | io2_oe_n | io3_oe_n)) else $error("quad lines split");
	AST_IDLE_FLOAT: assert property (@(posedge ref_clk) disable iff (sys_rst)
		select_n |-> io0_oe_n && io1_oe_n && io2_oe_n && io3_oe_n) else $error("driven idle");
	AST_DONE_PULSE: assert property (@(posedge ref_clk) disable iff (sys_rst)
		id_read_done |=> !id_read_done) else $error("long done");
	AST_COUNT_STEP: assert property (@(posedge ref_clk) disable iff (sys_rst)
		id_read_done |-> id_read_count == $past(id_read_count) + 8'h01) else $error("bad count");
endmodule : flash_id_readout_sva

// ---- verif/testbench.sv ----
// self-checking bench of the identification readout
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	import flash_id_pkg::*;
	logic       ref_clk = 1'b0;
	logic       sys_rst = 1'b0;
	logic       refused = 1'b0;
	logic       quad = 1'b0;
	logic       sck, sel_n, done;
	logic [3:0] dout, doe_n, hio, pin;
	logic [7:0] cnt;
	logic [7:0] exp_q[$];
	int         miscompares = 0;
	int         comparisons = 0;
	int         done_seen = 0;
	int         driven = 0;
	assign pin = (~doe_n & dout) | (doe_n & hio);
	always #20 ref_clk = ~ref_clk;
	always @(negedge ref_clk)
		if (done === 1'b1)
			done_seen++;
	always @(posedge sck)
		if (refused && doe_n !== 4'hf)
			driven++;
	flash_id_readout flash_id_readout_inst (.ref_clk, .sys_rst, .link_sck(sck), .select_n(sel_n),
		.io0_in(pin[0]), .io1_in(pin[1]), .io2_in(pin[2]), .io3_in(pin[3]),
		.io0_out(dout[0]), .io1_out(dout[1]), .io2_out(dout[2]), .io3_out(dout[3]),
		.io0_oe_n(doe_n[0]), .io1_oe_n(doe_n[1]), .io2_oe_n(doe_n[2]), .io3_oe_n(doe_n[3]),
		.id_read_done(done), .id_read_count(cnt));
	flash_host_model flash_host_model_inst (.sck, .sel_n, .hio, .rx(pin));
	// ----
	// compare, expectation and verdict
	// ----
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		comparisons++;
		if (seen !== want) begin
			miscompares++;
			$display("[ERR] %0t seen %h want %h", $time, seen, want);
		end
	endtask : check
	always @(flash_host_model_inst.got) begin
		if (exp_q.size() == 0)
			check(8'hff, 8'h00);
		else
			check(quad ? {4'h0, pin} : {7'h00, pin[1]}, exp_q.pop_front());
	end
	task automatic read_id(input logic [7:0] op, input int dum, input int n);
		logic [7:0] ids[5];
		int         k;
		ids = '{MFR_ID, {FAMILY_CODE, DENSITY_CODE}, {SUB_CODE, VERSION_CODE}, EXT_ID_LEN,
			{EXT_ID_HIGH, VARIANT_CODE}};
		quad = (op == OP_ID_QUAD);
		for (k = 0; k < n; k++)
			if (quad)
				exp_q.push_back((ids[k/2%2] >> (k%2 ? 0 : 4)) & 8'h0f);
			else
				exp_q.push_back({7'h00, ids[k/8%(op == OP_ID_STD ? 5 : 2)][7-k%8]});
		flash_host_model_inst.frame(op, dum, n);
	endtask : read_id
	task automatic give_verdict;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : give_verdict
	initial begin
		sys_rst <= 1'b1;
		repeat (5) @(posedge ref_clk);
		sys_rst <= 1'b0;
		read_id(OP_ID_SINGLE, 24, 40);
		read_id(OP_ID_QUAD, 12, 12);
		read_id(OP_ID_STD, 0, 48);
		refused <= 1'b1;
		flash_host_model_inst.frame(8'h5a, 16, 0);
		repeat (10) @(posedge ref_clk);
		check(cnt, 8'h06);
		check(8'(done_seen), 8'h06);
		check(8'(driven), 8'h00);
		check(8'(exp_q.size()), 8'h00);
		give_verdict;
	end
endmodule : testbench
bind flash_id_readout flash_id_readout_sva flash_id_readout_sva_inst (.ref_clk, .sys_rst, .link_sck,
	.select_n, .io0_oe_n, .io1_oe_n, .io2_oe_n, .io3_oe_n, .io1_out, .id_read_done, .id_read_count);
